/* inc/fbp_pkg.sv */
// ****************************************************************
// Flash block erase and protect: shared constants and types
// ****************************************************************
package fbp_pkg;

    // Array geometry: 128 KB of 32-bit words
    localparam int ADDR_W         = 17;
    localparam int DATA_W         = 32;
    localparam int WORD_ADDR_W    = 15;
    localparam int WORD_LSB       = 2;
    // Erase unit is 1 KB, protection unit is 2 KB
    localparam int ERASE_UNIT_LSB = 10;
    localparam int ERASE_UNIT_W   = 7;
    localparam int PROT_UNIT_LSB  = 11;
    localparam int PROT_UNIT_W    = 6;
    localparam int NUM_PROT       = 64;
    localparam int ERASE_CNT_W    = 8;
    localparam logic [7:0]  ERASE_CNT_LAST = 8'hFF;
    localparam logic [31:0] ERASED_WORD    = 32'hFFFFFFFF;
    localparam logic [31:0] ZERO_WORD      = 32'h00000000;

    // Per-unit protection setting; the spare code is treated as execute-only
    typedef enum logic [1:0] {
        FBP_PROT_OPEN  = 2'h0,
        FBP_PROT_RO    = 2'h1,
        FBP_PROT_XO    = 2'h2,
        FBP_PROT_SPARE = 2'h3
    } fbp_prot_t;

    // Request kinds from fetch path, data path and debugger
    typedef enum logic [2:0] {
        FBP_OP_FETCH   = 3'h0,
        FBP_OP_DREAD   = 3'h1,
        FBP_OP_DBGREAD = 3'h2,
        FBP_OP_PROG    = 3'h3,
        FBP_OP_ERASE   = 3'h4
    } fbp_op_t;

    typedef struct packed {
        fbp_op_t                 op;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       wdata;
    } fbp_req_t;

    typedef struct packed {
        logic                    valid;
        logic                    err;
        logic [DATA_W-1:0]       data;
    } fbp_rsp_t;

    // Gray sequence IDLE -> READ -> ERASE
    typedef enum logic [1:0] {
        FBP_ST_IDLE  = 2'h0,
        FBP_ST_READ  = 2'h1,
        FBP_ST_ERASE = 2'h3
    } fbp_state_t;

    localparam fbp_rsp_t RSP_RESET = '{valid: 1'b0, err: 1'b0, data: ZERO_WORD};

endpackage

/* logic/fbp_mem.sv */
// ****************************************************************
// Flash array storage, one port, registered read data
// ****************************************************************
module fbp_mem (
    // Clock
    input  wire logic                              clk,
    // Access port
    input  wire logic                              we,
    input  wire logic [fbp_pkg::WORD_ADDR_W-1:0]   addr,
    input  wire logic [fbp_pkg::DATA_W-1:0]        wdata,
    output      logic [fbp_pkg::DATA_W-1:0]        rdata_r
);

    logic [fbp_pkg::DATA_W-1:0] cells [0:(1 << fbp_pkg::WORD_ADDR_W)-1];

    // Write has priority; read data only refreshes on read cycles
    always_ff @(posedge clk) begin
        if (we) begin
            cells[addr] <= wdata;
        end else begin
            rdata_r <= cells[addr];
        end
    end

endmodule // fbp_mem

/* logic/fbp_ctrl.sv */
// How it works
// - Decode every address of 128 KB array.
// - Erase one 1 KB unit, others untouched.
// - Erased unit reads back all ones.
// - Protection per 2 KB unit pair.
// - Each unit: open, read-only or execute-only.
// - Read-only refuses erase and program.
// - Execute-only refuses erase and program.
// - Execute-only serves instruction fetches only.
// - Execute-only refuses data and debugger reads.
module fbp_ctrl (
    // Clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   nrst,
    // Protection setting per 2 KB unit
    input  wire logic [fbp_pkg::NUM_PROT-1:0][1:0]      prot_map,
    // Request side
    input  wire logic                                   req_valid,
    input  wire fbp_pkg::fbp_req_t                      req,
    output      logic                                   req_ready_r,
    // Answer side
    output      fbp_pkg::fbp_rsp_t                      rsp_r
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        fbp_pkg::fbp_state_t                     st;
        logic                                    ready;
        fbp_pkg::fbp_rsp_t                       rsp;
        logic [fbp_pkg::ERASE_UNIT_W-1:0]        erase_unit;
        logic [fbp_pkg::ERASE_CNT_W-1:0]         erase_cnt;
    } fbp_ctrl_state_t;

    localparam fbp_ctrl_state_t STATE_RESET = '{
        st:         fbp_pkg::FBP_ST_IDLE,
        ready:      1'b1,
        rsp:        fbp_pkg::RSP_RESET,
        erase_unit: '0,
        erase_cnt:  '0
    };

    fbp_ctrl_state_t                    s_r;
    fbp_ctrl_state_t                    s_nxt;
    // Array port
    logic                               mem_we;
    logic [fbp_pkg::WORD_ADDR_W-1:0]    mem_addr;
    logic [fbp_pkg::DATA_W-1:0]         mem_wdata;
    logic [fbp_pkg::DATA_W-1:0]         mem_rdata;
    // Decoded request and erase walk
    fbp_pkg::fbp_prot_t                 req_prot;
    logic                               req_take;
    logic                               req_ok;
    logic [fbp_pkg::WORD_ADDR_W-1:0]    req_word;
    logic [fbp_pkg::ERASE_UNIT_W-1:0]   req_eunit;
    logic [fbp_pkg::WORD_ADDR_W-1:0]    erase_word;
    logic                               erase_last;

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    // Setting of the 2 KB unit holding a byte address
    function automatic fbp_pkg::fbp_prot_t prot_of(
        input logic [fbp_pkg::NUM_PROT-1:0][1:0] map,
        input logic [fbp_pkg::ADDR_W-1:0]        addr
    );
        logic [fbp_pkg::PROT_UNIT_W-1:0] unit;
        unit    = addr[fbp_pkg::ADDR_W-1:fbp_pkg::PROT_UNIT_LSB];
        prot_of = fbp_pkg::fbp_prot_t'(map[unit]);
    endfunction

    // Whether a request kind may touch a unit of the given setting
    function automatic logic allowed(
        input fbp_pkg::fbp_op_t   op,
        input fbp_pkg::fbp_prot_t prot
    );
        logic ok;
        ok = 1'b1;
        case (prot)
            fbp_pkg::FBP_PROT_OPEN: begin
                ok = 1'b1;
            end
            fbp_pkg::FBP_PROT_RO: begin
                // Contents frozen, yet every read kind still passes
                ok = (op != fbp_pkg::FBP_OP_PROG) && (op != fbp_pkg::FBP_OP_ERASE);
            end
            fbp_pkg::FBP_PROT_XO: begin
                // Only the fetch path may see these words
                ok = (op == fbp_pkg::FBP_OP_FETCH);
            end
            default: begin
                // Spare code falls to the strictest setting rather than opening
                ok = (op == fbp_pkg::FBP_OP_FETCH);
            end
        endcase
        allowed = ok;
    endfunction

    // Answer word for a finished or refused request;
    // shared by every path that raises the answer pulse
    function automatic fbp_pkg::fbp_rsp_t answer(
        input logic                        err,
        input logic [fbp_pkg::DATA_W-1:0]  data
    );
        fbp_pkg::fbp_rsp_t r;
        r.valid = 1'b1;
        r.err   = err;
        r.data  = data;
        answer  = r;
    endfunction

    // ****************************************************************
    // Request decode
    // ****************************************************************
    // Protection looked at on the take edge only; a later change
    // does not stop an erase walk already under way
    assign req_prot   = prot_of(prot_map, req.addr);
    // Only an idle controller takes a request
    assign req_take   = req_valid && s_r.ready && (s_r.st == fbp_pkg::FBP_ST_IDLE);
    assign req_ok     = allowed(req.op, req_prot);
    // Low two address bits ignored: one word per request
    assign req_word   = req.addr[fbp_pkg::ADDR_W-1:fbp_pkg::WORD_LSB];
    assign req_eunit  = req.addr[fbp_pkg::ADDR_W-1:fbp_pkg::ERASE_UNIT_LSB];
    // Erase walks the unit one word per cycle; the last word ends the job
    assign erase_word = {s_r.erase_unit, s_r.erase_cnt};
    assign erase_last = (s_r.erase_cnt == fbp_pkg::ERASE_CNT_LAST);

    // ****************************************************************
    // Next state and array control
    // ****************************************************************
    // One request at a time; reads and erases drop ready while busy
    always_comb begin
        s_nxt           = s_r;
        s_nxt.rsp.valid = 1'b0;
        mem_we          = 1'b0;
        mem_addr        = req_word;
        mem_wdata       = req.wdata;
        case (s_r.st)
            fbp_pkg::FBP_ST_IDLE: begin
                // Array address follows the request so a read starts on the take edge
                if (req_take) begin
                    if (!req_ok) begin
                        // No array write, just the violation answer
                        s_nxt.rsp = answer(1'b1, fbp_pkg::ZERO_WORD);
                    end else begin
                        case (req.op)
                            fbp_pkg::FBP_OP_PROG: begin
                                // Plain overwrite, no merge with the old word
                                mem_we    = 1'b1;
                                s_nxt.rsp = answer(1'b0, fbp_pkg::ZERO_WORD);
                            end
                            fbp_pkg::FBP_OP_ERASE: begin
                                // Walk starts at the first word of the unit
                                s_nxt.erase_unit = req_eunit;
                                s_nxt.erase_cnt  = '0;
                                s_nxt.ready      = 1'b0;
                                s_nxt.st         = fbp_pkg::FBP_ST_ERASE;
                            end
                            fbp_pkg::FBP_OP_FETCH,
                            fbp_pkg::FBP_OP_DREAD,
                            fbp_pkg::FBP_OP_DBGREAD: begin
                                // Array register holds the word from the take edge on
                                s_nxt.ready = 1'b0;
                                s_nxt.st    = fbp_pkg::FBP_ST_READ;
                            end
                            default: begin
                                // Unknown kind answered as a violation
                                s_nxt.rsp = answer(1'b1, fbp_pkg::ZERO_WORD);
                            end
                        endcase
                    end
                end
            end
            fbp_pkg::FBP_ST_READ: begin
                // Request may already be released; only the array register counts
                s_nxt.rsp   = answer(1'b0, mem_rdata);
                s_nxt.ready = 1'b1;
                s_nxt.st    = fbp_pkg::FBP_ST_IDLE;
            end
            fbp_pkg::FBP_ST_ERASE: begin
                // One word per cycle, only inside the chosen 1 KB unit
                mem_we          = 1'b1;
                mem_addr        = erase_word;
                mem_wdata       = fbp_pkg::ERASED_WORD;
                s_nxt.erase_cnt = s_r.erase_cnt + 1'b1;
                if (erase_last) begin
                    // Whole unit written; ready again with the answer
                    s_nxt.rsp   = answer(1'b0, fbp_pkg::ZERO_WORD);
                    s_nxt.ready = 1'b1;
                    s_nxt.st    = fbp_pkg::FBP_ST_IDLE;
                end
            end
            default: begin
                // Unused state code: back to a clean idle
                s_nxt = STATE_RESET;
            end
        endcase
    end

    // Register the whole state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Array and outputs
    // ****************************************************************
    fbp_mem u_mem (
        .clk     (clk),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (mem_wdata),
        .rdata_r (mem_rdata)
    );

    // Outputs taken straight from state flops
    assign req_ready_r = s_r.ready;
    assign rsp_r       = s_r.rsp;

endmodule // fbp_ctrl

/* verification/fbp_monitor.sv */
// ****************************************
// Protection and answer timing checks
// ****************************************
module fbp_mon (
    // Clock and reset
    input wire logic                              clk,
    input wire logic                              nrst,
    // Protection and request
    input wire logic [fbp_pkg::NUM_PROT-1:0][1:0] prot_map,
    input wire logic                              req_valid,
    input wire fbp_pkg::fbp_req_t                 req,
    // Answer
    input wire logic                              req_ready_r,
    input wire fbp_pkg::fbp_rsp_t                 rsp_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pu;
    logic       take;
    logic       wr;
    logic       rd;
    // Unit setting and kind of the request on the bus
    assign pu = prot_map[req.addr[fbp_pkg::ADDR_W-1:fbp_pkg::PROT_UNIT_LSB]];
    assign take = req_valid && req_ready_r;
    assign wr = req.op inside {fbp_pkg::FBP_OP_PROG, fbp_pkg::FBP_OP_ERASE};
    assign rd = req.op inside {fbp_pkg::FBP_OP_DREAD, fbp_pkg::FBP_OP_DBGREAD};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    chk_ro_refuse: assert property (
        take && pu == 2'h1 && wr |=> rsp_r.valid && rsp_r.err)
        else $error("read-only write not refused");
    chk_ro_read: assert property (
        take && pu == 2'h1 && (rd || req.op == fbp_pkg::FBP_OP_FETCH)
        |=> !rsp_r.valid ##1 rsp_r.valid && !rsp_r.err)
        else $error("read-only read not served");
    chk_xo_write: assert property (
        take && pu[1] && wr |=> rsp_r.valid && rsp_r.err)
        else $error("execute-only write not refused");
    chk_xo_read: assert property (
        take && pu[1] && rd |=> rsp_r.valid && rsp_r.err && rsp_r.data == fbp_pkg::ZERO_WORD)
        else $error("execute-only data read not refused");
    chk_xo_fetch: assert property (
        take && pu[1] && req.op == fbp_pkg::FBP_OP_FETCH
        |=> !rsp_r.valid ##1 rsp_r.valid && !rsp_r.err)
        else $error("execute-only fetch not served");
    chk_open_prog: assert property (
        take && pu == 2'h0 && req.op == fbp_pkg::FBP_OP_PROG
        |=> rsp_r.valid && !rsp_r.err && req_ready_r)
        else $error("open program not accepted");
    chk_erase_span: assert property (
        take && pu == 2'h0 && req.op == fbp_pkg::FBP_OP_ERASE
        |=> (!rsp_r.valid && !req_ready_r) [*8] ##249 (rsp_r.valid && !rsp_r.err && req_ready_r))
        else $error("erase answer timing wrong");
    chk_refuse_blank: assert property (
        rsp_r.valid && rsp_r.err |-> rsp_r.data == fbp_pkg::ZERO_WORD)
        else $error("refusal carries data");
endmodule // fbp_mon

bind fbp_ctrl fbp_mon i_fbp_mon (.clk(clk), .nrst(nrst), .prot_map(prot_map),
    .req_valid(req_valid), .req(req), .req_ready_r(req_ready_r), .rsp_r(rsp_r));

/* verification/fbp_host.sv */
// ****************************************
// Requester standing for fetch, data and debug paths
// ****************************************
module fbp_host (
    // Clock
    input  wire logic              clk,
    // Bench side
    input  wire logic              go,
    input  wire fbp_pkg::fbp_req_t sreq,
    // Controller side
    input  wire logic              ready,
    output logic                   req_valid,
    output fbp_pkg::fbp_req_t      req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic taken;
    // Idle bus shows no request
    initial begin
        req_valid = 1'b0;
        req = '0;
        taken = 1'b0;
    end
    // Note the edge that takes the request
    always @(posedge clk) begin
        taken <= req_valid && ready;
    end
    // Held until taken; released fields are scrambled, not left valid
    always @(negedge clk) begin
        if (taken) begin
            req_valid <= 1'b0;
            req <= ~req;
        end else if (go) begin
            req_valid <= 1'b1;
            req <= sreq;
        end
    end
endmodule // fbp_host

/* verification/fbp_tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk = 1'b0;
    logic                  nrst = 1'b0;
    logic                  go = 1'b0;
    logic                  req_valid;
    logic                  req_ready_r;
    logic                  e;
    logic [31:0]           d;
    logic [63:0][1:0]      prot_map = '0;
    fbp_pkg::fbp_req_t     sreq = '0;
    fbp_pkg::fbp_req_t     req;
    fbp_pkg::fbp_rsp_t     rsp_r;
    int                    miscompares = 0;
    int                    samples_checked = 0;
    // 100 MHz clock
    always #5 clk = ~clk;
    fbp_host i_fbp_host (.clk(clk), .go(go), .sreq(sreq), .ready(req_ready_r),
        .req_valid(req_valid), .req(req));
    fbp_ctrl i_fbp_ctrl (.clk(clk), .nrst(nrst), .prot_map(prot_map), .req_valid(req_valid),
        .req(req), .req_ready_r(req_ready_r), .rsp_r(rsp_r));
    // Compare read data, then the violation flag
    task automatic cmp_w(string n, logic [31:0] x);
        samples_checked++;
        if (d !== x) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", n, x, d);
        end
    endtask
    task automatic cmp_e(string n, logic x);
        samples_checked++;
        if (e !== x) begin
            miscompares++;
            $display("[FAIL] %s exp %b got %b", n, x, e);
        end
    endtask
    // One request; bounded wait for its answer pulse
    task automatic xfer(int op, logic [16:0] a, logic [31:0] w);
        @(posedge clk);
        #1 go = 1'b1;
        sreq = '{fbp_pkg::fbp_op_t'(op), a, w};
        @(negedge clk);
        #1 go = 1'b0;
        for (int i = 0; i < 300 && rsp_r.valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (rsp_r.valid !== 1'b1) begin
            // Answer never came: counts against the run
            miscompares++;
            $display("[FAIL] answer exp 1 got %b", rsp_r.valid);
        end
        e = rsp_r.err;
        d = rsp_r.data;
    endtask
    // Erase one unit between two programmed neighbours
    task automatic sc_erase;
        logic [16:0] a[4] = '{17'h003FC, 17'h00400, 17'h007FC, 17'h00800};
        for (int i = 0; i < 4; i++) begin
            xfer(fbp_pkg::FBP_OP_PROG, a[i], 32'hC0DE0000 + i);
            cmp_e("prog", 1'b0);
        end
        xfer(fbp_pkg::FBP_OP_ERASE, 17'h00500, 32'h0);
        cmp_e("erase", 1'b0);
        for (int i = 0; i < 4; i++) begin
            xfer(fbp_pkg::FBP_OP_DREAD, a[i], 32'h0);
            cmp_w("erase rd", (i == 1 || i == 2) ? fbp_pkg::ERASED_WORD : 32'hC0DE0000 + i);
        end
    endtask
    // Read-only pair refuses changes, serves every read kind
    task automatic sc_ro;
        @(negedge clk);
        prot_map[1] = fbp_pkg::FBP_PROT_RO;
        xfer(fbp_pkg::FBP_OP_PROG, 17'h00800, 32'h0BAD0BAD);
        cmp_e("ro prog", 1'b1);
        xfer(fbp_pkg::FBP_OP_ERASE, 17'h00800, 32'h0);
        cmp_e("ro erase", 1'b1);
        for (int k = 0; k < 3; k++) begin
            xfer(k, 17'h00800, 32'h0);
            cmp_w("ro read", 32'hC0DE0003);
            cmp_e("ro read ok", 1'b0);
        end
        xfer(fbp_pkg::FBP_OP_PROG, 17'h007FC, 32'h0);
        cmp_e("pair prog", 1'b0);
        xfer(fbp_pkg::FBP_OP_PROG, 17'h00C00, 32'h0BAD0BAD);
        cmp_e("pair upper", 1'b1);
    endtask
    // Execute-only top unit: only fetches get through
    task automatic sc_xo;
        xfer(fbp_pkg::FBP_OP_PROG, 17'h1FFFC, 32'h5EC0DE77);
        @(negedge clk);
        prot_map[63] = fbp_pkg::FBP_PROT_XO;
        for (int k = 1; k < 5; k++) begin
            xfer(k, 17'h1FFFC, 32'h0);
            cmp_e("xo deny", 1'b1);
            cmp_w("xo data", 32'h0);
        end
        xfer(fbp_pkg::FBP_OP_FETCH, 17'h1FFFC, 32'h0);
        cmp_w("xo fetch", 32'h5EC0DE77);
        cmp_e("xo fetch ok", 1'b0);
        @(negedge clk);
        prot_map[63] = fbp_pkg::FBP_PROT_SPARE;
        xfer(fbp_pkg::FBP_OP_DREAD, 17'h1FFFC, 32'h0);
        cmp_e("spare", 1'b1);
    endtask
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Reset, then the scenarios in order
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        sc_erase;
        sc_ro;
        sc_xo;
        report_and_stop;
    end
    // Run needs about 330 cycles; allow plenty
    initial begin
        #20000;
        miscompares++;
        report_and_stop;
    end
endmodule // tb
